// ---- src/uip_pkg.sv ----
/*
 * Constants, field positions, source codes and carrier types for the
 * interrupt priority, FIFO setup and line format block.
 * Assumes a 3-bit parallel register port on the device clock.
 */
`default_nettype none
package uip_pkg;
	// Register port addresses
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam logic [7:0] LCR_EFR_KEY = 8'hbf;
	// Reset values
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [7:0] EFR_RESET = 8'h00;
	localparam logic [7:0] LCR_RESET = 8'h00;
	localparam logic [1:0] TRIG_RESET = 2'h0;
	// Field positions
	localparam int EFR_ENH = 4;
	localparam int EFR_ARTS = 6;
	localparam int EFR_ACTS = 7;
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LS = 2;
	localparam int IER_MS = 3;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int LCR_DLAB = 7;
	// Source codes in bits 5:0
	localparam logic [5:0] CODE_LS = 6'h06;
	localparam logic [5:0] CODE_TO = 6'h0c;
	localparam logic [5:0] CODE_RX = 6'h04;
	localparam logic [5:0] CODE_TX = 6'h02;
	localparam logic [5:0] CODE_MS = 6'h00;
	localparam logic [5:0] CODE_XS = 6'h10;
	localparam logic [5:0] CODE_CR = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;
	// Timeout figures, in characters and bits
	localparam logic [6:0] TO_CHARS = 7'h04;
	localparam logic [6:0] TO_EXTRA_BITS = 7'h0c;
	localparam logic [3:0] FRAME_OVERHEAD = 4'h2;
	localparam logic [3:0] MIN_WORD_BITS = 4'h5;
	// Pending sources, highest priority first
	typedef struct packed {
		logic ls;
		logic to;
		logic rx;
		logic tx;
		logic ms;
		logic xs;
		logic cr;
	} uip_pend_t;
	// Trigger field to character count
	function automatic logic [4:0] uip_trig(input logic [1:0] sel);
		case (sel)
			2'h0: uip_trig = 5'h01;
			2'h1: uip_trig = 5'h04;
			2'h2: uip_trig = 5'h08;
			default: uip_trig = 5'h0e;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- src/uip_rx_timeout.sv ----
/*
 * Receive timeout timer: counts bit ticks while the receive FIFO holds
 * data and no character moves.
 * Assumes a one-cycle bit_tick from the baud generator, same clock.
 */
`default_nettype none
module uip_rx_timeout
	import uip_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	input wire logic rx_nonempty,
	input wire logic restart,
	output logic timeout_q
);
	logic [6:0] count_q, count_d;
	logic timeout_d;
	logic [6:0] limit;

	// Four frames plus twelve bits; frame = start, data, stop
	assign limit = 7'(TO_CHARS * 7'(char_bits + FRAME_OVERHEAD)) + TO_EXTRA_BITS;

	////////////////////////////////////////////////////////////////////
	// Count and expiry
	always_comb begin
		count_d = count_q;
		timeout_d = timeout_q;
		if (restart || !rx_nonempty) begin
			count_d = 7'h00;
			timeout_d = 1'b0;
		end else if (bit_tick && !timeout_q) begin
			count_d = count_q + 7'h01;
			if (count_q + 7'h01 >= limit) begin
				timeout_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			count_q <= 7'h00;
			timeout_q <= 1'b0;
		end else begin
			count_q <= count_d;
			timeout_q <= timeout_d;
		end
	end

	property p_to_clear;
		@(posedge clock) disable iff (srst) restart |=> !timeout_q;
	endproperty
	a_to_clear: assert property (p_to_clear) else $error("timeout survived restart");
endmodule
`default_nettype wire

// ---- src/uip_core.sv ----
/*
 * Interrupt priority encoder, interrupt set/clear, FIFO setup and
 * line format registers behind the 3-bit parallel register port.
 * Assumes the serialisers and FIFOs outside supply counts, status and
 * event pulses on the same clock; only the CTS pin is asynchronous.
 */
`default_nettype none
module uip_core
	import uip_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic [2:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic irq,
	input wire logic [7:0] rx_data,
	input wire logic [4:0] rx_count,
	input wire logic [4:0] tx_count,
	input wire logic [7:0] line_cond,
	input wire logic [7:0] modem_cond,
	input wire logic xoff_match,
	input wire logic xon_match,
	input wire logic special_match,
	input wire logic rx_char,
	input wire logic bit_tick,
	input wire logic wake,
	input wire logic cts_n_pin,
	input wire logic rts_n_out,
	output logic [7:0] thr_data,
	output logic thr_write,
	output logic rhr_read,
	output logic lsr_read,
	output logic msr_read,
	output logic fifo_enable,
	output logic rx_fifo_reset,
	output logic tx_fifo_reset,
	output logic [4:0] rx_trig_level,
	output logic [4:0] tx_trig_level,
	output logic [3:0] word_length,
	output logic [7:0] line_format_reg,
	output logic [7:0] enhanced_feature_reg,
	output logic [7:0] interrupt_enable_reg
);
	logic [7:0] ier_q, ier_d, efr_q, efr_d, lcr_q, lcr_d, rdata_q, rdata_d, thr_q, thr_d;
	logic fen_q, fen_d, rxrst_q, rxrst_d, txrst_q, txrst_d;
	logic thrw_q, thrw_d, rhrr_q, rhrr_d, lsrr_q, lsrr_d, msrr_q, msrr_d;
	logic [1:0] rxtrig_q, rxtrig_d, txtrig_q, txtrig_d;
	uip_pend_t pend_q, pend_d, pend_en;
	logic xoff_q, xoff_d, spec_q, spec_d, wake_q, wake_d;
	logic cts_s1_q, cts_s2_q, cts_prev_q, rts_prev_q, lerr_prev_q, merr_prev_q;
	logic [4:0] tx_prev_q;
	logic tx_over_q, tx_over_d;
	logic timeout;
	logic enh, efr_sel, rd_isr, rd_data, wr_data_reg;
	logic [5:0] isr_code;
	logic [4:0] rx_trig, tx_trig;
	logic tx_event, rx_ready, cts_rise, rts_rise, lerr, merr;

	////////////////////////////////////////////////////////////////////
	// Decode helpers
	assign enh = efr_q[EFR_ENH];
	assign efr_sel = (lcr_q == LCR_EFR_KEY);
	assign rd_isr = bus_rd && bus_addr == ADDR_ISR && !efr_sel;
	assign rd_data = bus_rd && bus_addr == ADDR_DATA && !lcr_q[LCR_DLAB];
	assign wr_data_reg = bus_wr && bus_addr == ADDR_DATA && !lcr_q[LCR_DLAB];
	assign rx_trig = fen_q ? uip_trig(rxtrig_q) : 5'h01;
	assign tx_trig = fen_q ? uip_trig(txtrig_q) : 5'h01;

	// CTS pin crosses in through two flops; edges seen only after that
	assign cts_rise = cts_s2_q && !cts_prev_q;
	assign rts_rise = rts_n_out && !rts_prev_q;
	assign lerr = |line_cond[4:1];
	assign merr = |modem_cond[3:0];

	// Receive ready is a level against the trigger, no latch needed
	assign rx_ready = fen_q ? (rx_count >= rx_trig) : (rx_count != 5'h00);

	// Falls below trigger after a reload above it, otherwise only on empty
	assign tx_event = tx_over_q ? (tx_count < tx_trig && tx_prev_q >= tx_trig)
		: (tx_count == 5'h00 && tx_prev_q != 5'h00);

	////////////////////////////////////////////////////////////////////
	// Receive timeout timer
	uip_rx_timeout u_timeout (
		.clock(clock),
		.srst(srst),
		.bit_tick(bit_tick),
		.char_bits(word_length),
		.rx_nonempty(rx_count != 5'h00),
		.restart(rx_char || rhrr_q),
		.timeout_q(timeout)
	);

	////////////////////////////////////////////////////////////////////
	// Enabled sources and priority encode
	always_comb begin
		pend_en = pend_q;
		pend_en.ls = pend_q.ls && ier_q[IER_LS];
		pend_en.to = timeout && ier_q[IER_RX] && fen_q;
		pend_en.rx = rx_ready && ier_q[IER_RX];
		pend_en.tx = pend_q.tx && ier_q[IER_TX];
		pend_en.ms = pend_q.ms && ier_q[IER_MS];
		pend_en.xs = (xoff_q || spec_q) && enh;
		pend_en.cr = pend_q.cr && enh;
		// Fixed priority; lower sources wait behind the one shown
		if (pend_en.ls) isr_code = CODE_LS;
		else if (pend_en.to) isr_code = CODE_TO;
		else if (pend_en.rx) isr_code = CODE_RX;
		else if (pend_en.tx) isr_code = CODE_TX;
		else if (pend_en.ms) isr_code = CODE_MS;
		else if (pend_en.xs) isr_code = CODE_XS;
		else if (pend_en.cr) isr_code = CODE_CR;
		else isr_code = CODE_NONE;
	end

	assign irq = (|pend_en) || wake_q;

	////////////////////////////////////////////////////////////////////
	// Registers, sticky sources and read data
	always_comb begin
		ier_d = ier_q;
		efr_d = efr_q;
		lcr_d = lcr_q;
		thr_d = thr_q;
		fen_d = fen_q;
		rxtrig_d = rxtrig_q;
		txtrig_d = txtrig_q;
		rxrst_d = 1'b0;
		txrst_d = 1'b0;
		thrw_d = wr_data_reg;
		rhrr_d = rd_data;
		lsrr_d = bus_rd && bus_addr == ADDR_LSR;
		msrr_d = bus_rd && bus_addr == ADDR_MSR;
		rdata_d = rdata_q;
		pend_d = pend_q;
		xoff_d = xoff_q;
		spec_d = spec_q;
		wake_d = wake_q;
		tx_over_d = tx_over_q;
		// Writes
		if (bus_wr) begin
			case (bus_addr)
				ADDR_DATA: if (!lcr_q[LCR_DLAB]) thr_d = bus_wdata;
				ADDR_IER: begin
					if (!lcr_q[LCR_DLAB]) begin
						ier_d[3:0] = bus_wdata[3:0];
						if (enh) ier_d[7:4] = bus_wdata[7:4];
					end
				end
				ADDR_ISR: begin
					if (efr_sel) begin
						efr_d = bus_wdata;
					end else if (bus_wdata[FCR_EN]) begin
						fen_d = 1'b1;
						rxrst_d = bus_wdata[FCR_RXRST];
						txrst_d = bus_wdata[FCR_TXRST];
						rxtrig_d = bus_wdata[7:6];
						if (enh) txtrig_d = bus_wdata[5:4];
					end else begin
						fen_d = 1'b0;
					end
				end
				ADDR_LCR: lcr_d = bus_wdata;
				default: ;
			endcase
		end
		// Clears first, so a same-cycle set below wins
		if (bus_rd && bus_addr == ADDR_LSR) pend_d.ls = 1'b0;
		if (bus_rd && bus_addr == ADDR_MSR) begin
			pend_d.ms = 1'b0;
			pend_d.cr = 1'b0;
		end
		if (wr_data_reg) pend_d.tx = 1'b0;
		if (rd_isr) begin
			if (isr_code == CODE_TX) pend_d.tx = 1'b0;
			if (isr_code == CODE_XS) begin
				xoff_d = 1'b0;
				spec_d = 1'b0;
			end
			if (isr_code == CODE_NONE) wake_d = 1'b0;
		end
		if (xon_match) xoff_d = 1'b0;
		if (rx_char) spec_d = 1'b0;
		// Sets
		if (lerr && !lerr_prev_q) pend_d.ls = 1'b1;
		if (merr && !merr_prev_q) pend_d.ms = 1'b1;
		if (tx_event) pend_d.tx = 1'b1;
		// Enabling the source on an empty FIFO must still interrupt
		if (bus_wr && bus_addr == ADDR_IER && !lcr_q[LCR_DLAB] && bus_wdata[IER_TX]
			&& !ier_q[IER_TX] && tx_count == 5'h00) pend_d.tx = 1'b1;
		if (xoff_match && ier_q[IER_XOFF] && enh) xoff_d = 1'b1;
		if (special_match && efr_q[5] && ier_q[IER_XOFF] && enh) spec_d = 1'b1;
		// The CTS enable with enhanced mode arms the edge; auto flow need not be on
		if (cts_rise && ier_q[IER_CTS] && enh) pend_d.cr = 1'b1;
		if (rts_rise && ier_q[IER_RTS] && efr_q[EFR_ARTS] && enh) pend_d.cr = 1'b1;
		if (wake) wake_d = 1'b1;
		pend_d.to = 1'b0;
		pend_d.rx = 1'b0;
		pend_d.xs = 1'b0;
		// Reload tracking for the transmit trigger
		if (tx_count > tx_trig) tx_over_d = 1'b1;
		else if (tx_count == 5'h00) tx_over_d = 1'b0;
		// Read data, registered
		if (bus_rd) begin
			case (bus_addr)
				ADDR_DATA: rdata_d = lcr_q[LCR_DLAB] ? 8'h00 : rx_data;
				ADDR_IER: rdata_d = lcr_q[LCR_DLAB] ? 8'h00 : ier_q;
				ADDR_ISR: rdata_d = efr_sel ? efr_q : {{2{fen_q}}, isr_code};
				ADDR_LCR: rdata_d = lcr_q;
				ADDR_LSR: rdata_d = line_cond;
				ADDR_MSR: rdata_d = modem_cond;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ier_q <= IER_RESET;
			efr_q <= EFR_RESET;
			lcr_q <= LCR_RESET;
			thr_q <= 8'h00;
			fen_q <= 1'b0;
			rxtrig_q <= TRIG_RESET;
			txtrig_q <= TRIG_RESET;
			rxrst_q <= 1'b0;
			txrst_q <= 1'b0;
			thrw_q <= 1'b0;
			rhrr_q <= 1'b0;
			lsrr_q <= 1'b0;
			msrr_q <= 1'b0;
			rdata_q <= 8'h00;
			pend_q <= '0;
			xoff_q <= 1'b0;
			spec_q <= 1'b0;
			wake_q <= 1'b0;
			tx_over_q <= 1'b0;
			tx_prev_q <= 5'h00;
			// Idle level of both active-low lines, so no false edge after reset
			cts_s1_q <= 1'b1;
			cts_s2_q <= 1'b1;
			cts_prev_q <= 1'b1;
			rts_prev_q <= 1'b1;
			lerr_prev_q <= 1'b0;
			merr_prev_q <= 1'b0;
		end else begin
			ier_q <= ier_d;
			efr_q <= efr_d;
			lcr_q <= lcr_d;
			thr_q <= thr_d;
			fen_q <= fen_d;
			rxtrig_q <= rxtrig_d;
			txtrig_q <= txtrig_d;
			rxrst_q <= rxrst_d;
			txrst_q <= txrst_d;
			thrw_q <= thrw_d;
			rhrr_q <= rhrr_d;
			lsrr_q <= lsrr_d;
			msrr_q <= msrr_d;
			rdata_q <= rdata_d;
			pend_q <= pend_d;
			xoff_q <= xoff_d;
			spec_q <= spec_d;
			wake_q <= wake_d;
			tx_over_q <= tx_over_d;
			tx_prev_q <= tx_count;
			cts_s1_q <= cts_n_pin;
			cts_s2_q <= cts_s1_q;
			cts_prev_q <= cts_s2_q;
			rts_prev_q <= rts_n_out;
			lerr_prev_q <= lerr;
			merr_prev_q <= merr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign bus_rdata = rdata_q;
	assign thr_data = thr_q;
	assign thr_write = thrw_q;
	assign rhr_read = rhrr_q;
	assign lsr_read = lsrr_q;
	assign msr_read = msrr_q;
	assign fifo_enable = fen_q;
	assign rx_fifo_reset = rxrst_q;
	assign tx_fifo_reset = txrst_q;
	assign rx_trig_level = uip_trig(rxtrig_q);
	assign tx_trig_level = uip_trig(txtrig_q);
	assign word_length = MIN_WORD_BITS + {2'b00, lcr_q[1:0]};
	assign line_format_reg = lcr_q;
	assign enhanced_feature_reg = efr_q;
	assign interrupt_enable_reg = ier_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_none_code;
		@(posedge clock) disable iff (srst)
		rd_isr && !(|pend_en) |=> bus_rdata[5:0] == CODE_NONE;
	endproperty
	a_none_code: assert property (p_none_code) else $error("idle code wrong");

	property p_ls_first;
		@(posedge clock) disable iff (srst)
		rd_isr && pend_en.ls |=> bus_rdata[5:0] == CODE_LS;
	endproperty
	a_ls_first: assert property (p_ls_first) else $error("line status not first");

	property p_fifo_bits;
		@(posedge clock) disable iff (srst)
		rd_isr |=> bus_rdata[7:6] == {2{$past(fen_q)}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits) else $error("fifo bits wrong");

	property p_fcr_ignore;
		@(posedge clock) disable iff (srst)
		bus_wr && bus_addr == ADDR_ISR && !efr_sel && !bus_wdata[FCR_EN]
		|=> !fen_q && $stable(rxtrig_q) && !rx_fifo_reset;
	endproperty
	a_fcr_ignore: assert property (p_fcr_ignore) else $error("setup bits taken");

	property p_rx_reset;
		@(posedge clock) disable iff (srst)
		bus_wr && bus_addr == ADDR_ISR && !efr_sel && bus_wdata[FCR_EN] && bus_wdata[FCR_RXRST]
		|=> rx_fifo_reset ##1 !rx_fifo_reset;
	endproperty
	a_rx_reset: assert property (p_rx_reset) else $error("rx reset not one pulse");

	property p_tx_lock;
		@(posedge clock) disable iff (srst)
		bus_wr && bus_addr == ADDR_ISR && !efr_sel && !enh |=> $stable(txtrig_q);
	endproperty
	a_tx_lock: assert property (p_tx_lock) else $error("tx trigger written");

	property p_thr_clear;
		@(posedge clock) disable iff (srst)
		wr_data_reg && !tx_event |=> !pend_q.tx && thr_write;
	endproperty
	a_thr_clear: assert property (p_thr_clear) else $error("tx source not cleared");

	property p_cts;
		@(posedge clock) disable iff (srst)
		cts_rise && ier_q[IER_CTS] && enh |=> pend_q.cr ##0 irq;
	endproperty
	a_cts: assert property (p_cts) else $error("cts edge lost");

	property p_wlen;
		@(posedge clock) disable iff (srst)
		bus_wr && bus_addr == ADDR_LCR |=> word_length == 4'h5 + {2'b00, $past(bus_wdata[1:0])};
	endproperty
	a_wlen: assert property (p_wlen) else $error("word length wrong");

	property p_ls_irq;
		@(posedge clock) disable iff (srst)
		lerr && !lerr_prev_q && ier_q[IER_LS] |=> irq;
	endproperty
	a_ls_irq: assert property (p_ls_irq) else $error("line status irq missing");

	c_timeout: cover property (@(posedge clock) disable iff (srst) rd_isr && isr_code == CODE_TO);
	c_tx_irq: cover property (@(posedge clock) disable iff (srst) tx_event && ier_q[IER_TX]);
	c_xoff: cover property (@(posedge clock) disable iff (srst) rd_isr && isr_code == CODE_XS);
endmodule
`default_nettype wire

// ---- tb/uip_host.sv ----
/* Host model: byte reads and writes on the 3-bit register port.
   Assumes the core takes a strobe at the rising edge it is seen high. */
`default_nettype none
module uip_host (
	input wire logic clock,
	input wire logic [7:0] bus_rdata,
	output logic [2:0] bus_addr,
	output logic bus_wr,
	output logic bus_rd,
	output logic [7:0] bus_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bus_addr = 3'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// Write: address, data and strobe held for one clock, then strobe dropped
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clock);
		bus_wr <= 1'b0;
		#1;
	endtask
	// Data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask
endmodule
`default_nettype wire

// ---- tb/uart_irq_priority_fifo_control_tb.sv ----
/* Self-checking bench for uip_core, host model on the register port.
   Assumes single clock; FIFO side inputs are driven directly here. */
`default_nettype none
module uart_irq_priority_fifo_control_tb import uip_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, srst, bus_wr, bus_rd, bit_tick, xoff_match, xon_match, cts_n_pin;
	logic [2:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata, line_cond, modem_cond, thr_data, rd_d;
	logic [4:0] rx_count, tx_count, rx_trig_level, tx_trig_level;
	logic [3:0] word_length;
	logic irq, thr_write, fifo_enable, rx_fifo_reset, tx_fifo_reset;
	int num_errors = 0;
	int comparisons = 0;
	uip_host uip_host_inst (.clock(clock), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));
	// Five inputs tied: no sleep, RTS flow or special char traffic here
	uip_core uip_core_inst (.clock(clock), .srst(srst), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.irq(irq), .rx_data(8'h00), .rx_count(rx_count), .tx_count(tx_count),
		.line_cond(line_cond), .modem_cond(modem_cond), .xoff_match(xoff_match),
		.xon_match(xon_match), .special_match(1'b0), .rx_char(1'b0), .bit_tick(bit_tick),
		.wake(1'b0), .cts_n_pin(cts_n_pin), .rts_n_out(1'b1), .thr_data(thr_data),
		.thr_write(thr_write), .rhr_read(), .lsr_read(), .msr_read(),
		.fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset),
		.tx_fifo_reset(tx_fifo_reset), .rx_trig_level(rx_trig_level),
		.tx_trig_level(tx_trig_level), .word_length(word_length), .line_format_reg(),
		.enhanced_feature_reg(), .interrupt_enable_reg());
	////////////////////////////////////////////////////////////////
	// Clock and a watchdog well beyond the few hundred cycles used
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		finish_test();
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic src(input logic [7:0] e);
		uip_host_inst.rd(ADDR_ISR, rd_d);
		chk("source", e, rd_d);
	endtask
	// Settle one step past the edge so registered outputs are stable
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		src(8'h01);
		chk("fifo_en", 8'h00, {7'h0, fifo_enable});
		chk("rx_trig", 8'h01, {3'h0, rx_trig_level});
		chk("word", 8'h05, {4'h0, word_length});
		$display("reset done");
	endtask
	task automatic t_format();
		for (int i = 0; i < 4; i++) begin
			uip_host_inst.wr(ADDR_LCR, 8'(i));
			chk("word", 8'(5 + i), {4'h0, word_length});
		end
		uip_host_inst.rd(ADDR_LCR, rd_d);
		chk("lcr", 8'h03, rd_d);
		uip_host_inst.wr(ADDR_LCR, 8'h00);
		$display("format done");
	endtask
	task automatic t_setup();
		uip_host_inst.wr(ADDR_ISR, 8'hc0);
		chk("rx_trig", 8'h01, {3'h0, rx_trig_level});
		uip_host_inst.wr(ADDR_ISR, 8'hf7);
		chk("fifo_en", 8'h01, {7'h0, fifo_enable});
		chk("rx_rst", 8'h01, {7'h0, rx_fifo_reset});
		chk("tx_rst", 8'h01, {7'h0, tx_fifo_reset});
		cyc(1);
		chk("resets", 8'h00, {6'h0, rx_fifo_reset, tx_fifo_reset});
		chk("rx_trig", 8'h0e, {3'h0, rx_trig_level});
		chk("tx_trig", 8'h01, {3'h0, tx_trig_level});
		src(8'hc1);
		$display("setup done");
	endtask
	// Three sources at once are served strictly by priority
	task automatic t_priority();
		uip_host_inst.wr(ADDR_IER, 8'h0d);
		@(posedge clock);
		line_cond <= 8'h02;
		modem_cond <= 8'h01;
		rx_count <= 5'h0e;
		cyc(3);
		chk("irq", 8'h01, {7'h0, irq});
		src(8'hc6);
		uip_host_inst.rd(ADDR_LSR, rd_d);
		src(8'hc4);
		@(posedge clock);
		rx_count <= 5'h0d;
		cyc(2);
		src(8'hc0);
		uip_host_inst.rd(ADDR_MSR, rd_d);
		src(8'hc1);
		chk("irq", 8'h00, {7'h0, irq});
		$display("priority done");
	endtask
	// Word length 5: 4*(5+2)+12 = 40 ticks with data below trigger
	task automatic t_timeout();
		@(posedge clock);
		rx_count <= 5'h01;
		bit_tick <= 1'b1;
		cyc(25);
		src(8'hc1);
		cyc(30);
		src(8'hcc);
		@(posedge clock);
		bit_tick <= 1'b0;
		uip_host_inst.rd(ADDR_DATA, rd_d);
		src(8'hc1);
		@(posedge clock);
		rx_count <= 5'h00;
		$display("timeout done");
	endtask
	task automatic t_tx();
		@(posedge clock);
		tx_count <= 5'h00;
		uip_host_inst.wr(ADDR_IER, 8'h0f);
		cyc(2);
		src(8'hc2);
		src(8'hc1);
		@(posedge clock);
		tx_count <= 5'h01;
		@(posedge clock);
		tx_count <= 5'h00;
		cyc(3);
		chk("irq", 8'h01, {7'h0, irq});
		uip_host_inst.wr(ADDR_DATA, 8'h5a);
		chk("thr", 8'h5a, thr_data);
		src(8'hc1);
		$display("tx done");
	endtask
	task automatic pulse_x(input logic off);
		@(posedge clock);
		xoff_match <= off;
		xon_match <= ~off;
		@(posedge clock);
		xoff_match <= 1'b0;
		xon_match <= 1'b0;
		cyc(2);
	endtask
	task automatic t_enh();
		uip_host_inst.wr(ADDR_LCR, LCR_EFR_KEY);
		uip_host_inst.wr(ADDR_ISR, 8'h90);
		uip_host_inst.wr(ADDR_LCR, 8'h00);
		uip_host_inst.wr(ADDR_IER, 8'ha0);
		pulse_x(1'b1);
		pulse_x(1'b0);
		src(8'hc1);
		pulse_x(1'b1);
		src(8'hd0);
		src(8'hc1);
		@(posedge clock);
		cts_n_pin <= 1'b0;
		repeat (5) @(posedge clock);
		cts_n_pin <= 1'b1;
		cyc(6);
		src(8'he0);
		uip_host_inst.rd(ADDR_MSR, rd_d);
		src(8'hc1);
		uip_host_inst.wr(ADDR_ISR, 8'h31);
		chk("tx_trig", 8'h0e, {3'h0, tx_trig_level});
		chk("rx_trig", 8'h01, {3'h0, rx_trig_level});
		$display("enhanced done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		bit_tick = 1'b0;
		xoff_match = 1'b0;
		xon_match = 1'b0;
		cts_n_pin = 1'b1;
		line_cond = 8'h00;
		modem_cond = 8'h00;
		rx_count = 5'h00;
		tx_count = 5'h02;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		t_reset();
		t_format();
		t_setup();
		t_priority();
		t_timeout();
		t_tx();
		t_enh();
		finish_test();
	end
endmodule
`default_nettype wire
